/* hdl/minicomputer_instruction_execute.sv */
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
// Functional notes
// [RQ1] Arithmetic left shift: bits 0-14 up, zero into bit 0, sign kept.
// [RQ2] Left shift clear sign: bits 0-14 up, zero into bit 0, sign zero.
// [RQ3] Arithmetic right shift: all bits down, sign copied into bit 14, sign kept.
// [RQ4] Clear-complement accumulator leaves all sixteen bits one.
// [RQ5] Clear accumulator forces all sixteen bits of A or B to zero.
// [RQ6] Complement accumulator inverts all sixteen bits.
// [RQ7] Extend bit: clear zeroes, complement inverts, clear-complement sets it.
// [RQ8] Clear control resets addressed card control; select code 00 resets all.
// [RQ9] Clear flag resets addressed card flag; code 00 drops interrupt enable only.
// [RQ10] Clear flag and clear control in one word both take effect.
// [RQ11] Clear overflow resets the overflow bit.
// [RQ12] Compare skips by two when memory differs from accumulator, else one.
// [RQ13] Rotate extend left: bit 15 to extend, old extend to bit 0.
// [RQ14] Rotate extend right: bit 0 to extend, old extend to bit 15.
// [RQ15] Halt stops, shows halt, blocks interrupts, keeps word, P is location plus one.
// [RQ16] Increment adds one; carry may set extend, overflow may set overflow.
// [RQ17] OR memory word into A, memory unchanged.
// [RQ18] Increment memory, skip when zero; extend and overflow untouched.
// [RQ19] Jump loads P with the instruction address field.
// [RQ20] Subroutine call stores P plus one at X, continues at X plus one.
// [RQ21] Load replaces selected accumulator with memory word.
// [RQ22] Load input takes addressed card buffer into selected accumulator.
// [RQ23] Column one shift runs first, column four shift runs last.
// [RQ24] Without skip or jump, P advances by one.
module minicomputer_instruction_execute #(
  parameter int IO_SETTLE = exec_pkg::IO_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Interface cards
  input  wire logic [15:0] i_io_data,
  output logic      [5:0]  o_io_sel,
  output logic             o_ctl_clear,
  output logic             o_ctl_clear_all,
  output logic             o_flag_clear,
  output logic             o_int_enable,
  output logic             o_halt
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    exec_pkg::exec_state_type st;
    logic [2:0]               cnt;
    logic [15:0]              ir;
    logic [15:0]              acc_a;
    logic [15:0]              acc_b;
    logic [14:0]              pc;
    logic                     ext;
    logic                     ovf;
    logic                     halt;
    logic                     ien;
    logic                     ien_o;
    logic                     memwr;
    logic [15:0]              mem_opnd;
    logic [15:0]              mem_wdata;
    logic [14:0]              mem_waddr;
    logic [15:0]              io_s1;
    logic [15:0]              io_s2;
    logic [15:0]              io_s3;
    logic [15:0]              io_stable;
    logic [5:0]               io_sel;
    logic                     ctl_clr;
    logic                     ctl_clr_all;
    logic                     flag_clr;
    logic                     wait_r;
    logic [31:0]              rdata;
  } state_type;

  state_type r;
  state_type r_nxt;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [16:0] shift_op(input logic [2:0]  op,
                                           input logic [15:0] v,
                                           input logic        e);
    logic [16:0] res;
    res = {e, v};
    case (op)
      exec_pkg::SH_ALS: res = {e, v[15], v[13:0], 1'b0};   // RQ1
      exec_pkg::SH_ARS: res = {e, v[15], v[15:1]};         // RQ3
      exec_pkg::SH_RAL: res = {e, v[14:0], v[15]};
      exec_pkg::SH_RAR: res = {e, v[0], v[15:1]};
      exec_pkg::SH_ALR: res = {e, 1'b0, v[13:0], 1'b0};    // RQ2
      exec_pkg::SH_EXTR: res = {v[0], e, v[15:1]};         // RQ14
      exec_pkg::SH_EXTL: res = {v[15], v[14:0], e};        // RQ13
      exec_pkg::SH_ALF: res = {e, v[11:0], v[15:12]};
      default:          res = {e, v};
    endcase
    return res;
  endfunction : shift_op

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        req;
    logic [15:0] acc;
    logic [15:0] wd;
    logic [16:0] t;
    logic [14:0] ea;
    logic [14:0] tgt;
    logic        e;
    logic        e0;
    logic        skip;
    logic        jump;
    logic        wr_acc;
    logic        ts;
    logic        tl;
    logic        tz;
    logic [5:0]  sc;
    req    = i_avs_read | i_avs_write;
    acc    = 16'h0000;
    wd     = i_avs_writedata[15:0];
    t      = 17'h00000;
    ea     = 15'h0000;
    tgt    = 15'h0000;
    e      = 1'b0;
    e0     = 1'b0;
    skip   = 1'b0;
    jump   = 1'b0;
    wr_acc = 1'b0;
    ts     = 1'b0;
    tl     = 1'b0;
    tz     = 1'b0;
    sc     = r.ir[5:0];
    r_nxt  = r;
    r_nxt.ctl_clr     = 1'b0;
    r_nxt.ctl_clr_all = 1'b0;
    r_nxt.flag_clr    = 1'b0;
    // Card buffer synchroniser; a word counts once two stages agree
    r_nxt.io_s1 = i_io_data;
    r_nxt.io_s2 = r.io_s1;
    r_nxt.io_s3 = r.io_s2;
    if (r.io_s2 == r.io_s3) begin
      r_nxt.io_stable = r.io_s3;
    end

    // ****************************************
    // Bus slave: one wait cycle, then answer
    // ****************************************
    r_nxt.wait_r = !(req && r.wait_r);
    if (i_avs_read && r.wait_r) begin
      case (i_avs_address)
        exec_pkg::OFS_INSTR:     r_nxt.rdata = {16'h0000, r.ir};
        exec_pkg::OFS_ACC_A:     r_nxt.rdata = {16'h0000, r.acc_a};
        exec_pkg::OFS_ACC_B:     r_nxt.rdata = {16'h0000, r.acc_b};
        exec_pkg::OFS_PCOUNT:    r_nxt.rdata = {17'h00000, r.pc};
        exec_pkg::OFS_FLAGS:     r_nxt.rdata = {26'h0000000, r.memwr,
                                               r.st != exec_pkg::ST_IDLE,
                                               r.ien, r.halt, r.ovf, r.ext};
        exec_pkg::OFS_MEM_OPND:  r_nxt.rdata = {16'h0000, r.mem_opnd};
        exec_pkg::OFS_MEM_WDATA: r_nxt.rdata = {16'h0000, r.mem_wdata};
        exec_pkg::OFS_MEM_WADDR: r_nxt.rdata = {17'h00000, r.mem_waddr};
        default:                 r_nxt.rdata = 32'h00000000;
      endcase
    end
    if (i_avs_read && !r.wait_r && i_avs_address == exec_pkg::OFS_MEM_WDATA) begin
      r_nxt.memwr = 1'b0;
    end
    if (i_avs_write && !r.wait_r) begin
      case (i_avs_address)
        exec_pkg::OFS_INSTR: begin
          if (r.st == exec_pkg::ST_IDLE && !r.halt) begin
            r_nxt.ir     = wd;
            r_nxt.io_sel = wd[5:0];
            r_nxt.cnt    = 3'h0;
            if (wd[15:12] == exec_pkg::GRP_IO && wd[10] && wd[8:6] == exec_pkg::IO_LOAD) begin
              r_nxt.st = exec_pkg::ST_IOWAIT;
            end else begin
              r_nxt.st = exec_pkg::ST_EXEC;
            end
          end
        end
        exec_pkg::OFS_ACC_A:    r_nxt.acc_a = merge16(r.acc_a, wd, i_avs_byteenable[1:0]);
        exec_pkg::OFS_ACC_B:    r_nxt.acc_b = merge16(r.acc_b, wd, i_avs_byteenable[1:0]);
        exec_pkg::OFS_PCOUNT:   r_nxt.pc = 15'(merge16({1'b0, r.pc}, wd, i_avs_byteenable[1:0]));
        exec_pkg::OFS_MEM_OPND: begin
          r_nxt.mem_opnd = merge16(r.mem_opnd, wd, i_avs_byteenable[1:0]);
        end
        exec_pkg::OFS_FLAGS: begin
          if (i_avs_byteenable[0]) begin
            r_nxt.ext = wd[exec_pkg::FLG_EXT];
            r_nxt.ovf = wd[exec_pkg::FLG_OVF];
            r_nxt.ien = wd[exec_pkg::FLG_IEN];
            if (wd[exec_pkg::FLG_HALT]) begin
              r_nxt.halt = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // ****************************************
    // Sequencer and execution
    // ****************************************
    case (r.st)
      exec_pkg::ST_IDLE: ;
      exec_pkg::ST_IOWAIT: begin
        r_nxt.cnt = r.cnt + 3'h1;
        if (r.cnt == 3'(IO_SETTLE - 1)) begin
          r_nxt.st = exec_pkg::ST_EXEC;
        end
      end
      exec_pkg::ST_EXEC: begin
        r_nxt.st = exec_pkg::ST_IDLE;
        acc = r.ir[11] ? r.acc_b : r.acc_a;
        e   = r.ext;
        ea  = {r.ir[10] ? r.pc[14:10] : 5'h00, r.ir[9:0]};
        if (r.ir[15:12] == exec_pkg::GRP_REG && !r.ir[10]) begin
          wr_acc = 1'b1;
          if (r.ir[9]) begin
            {e, acc} = shift_op(r.ir[8:6], acc, e);                  // RQ23
          end
          if (r.ir[5]) begin
            e = 1'b0;
          end
          skip = r.ir[3] && !acc[0];
          if (r.ir[4]) begin
            {e, acc} = shift_op(r.ir[2:0], acc, e);                  // RQ23
          end
        end else if (r.ir[15:12] == exec_pkg::GRP_REG) begin
          wr_acc = 1'b1;
          e0 = e;
          case (r.ir[9:8])
            exec_pkg::AC_CLR: acc = 16'h0000;                        // RQ5
            exec_pkg::AC_CMP: acc = ~acc;                            // RQ6
            exec_pkg::AC_SET: acc = 16'hFFFF;                        // RQ4
            default: ;
          endcase
          case (r.ir[7:6])
            exec_pkg::AC_CLR: e = 1'b0;                              // RQ7
            exec_pkg::AC_CMP: e = ~e;                                // RQ7
            exec_pkg::AC_SET: e = 1'b1;                              // RQ7
            default: ;
          endcase
          ts = acc[15];
          tl = acc[0];
          if (r.ir[2]) begin
            t = {1'b0, acc} + 17'h00001;                             // RQ16
            if (t[16]) begin
              e = 1'b1;
            end
            if (acc == 16'h7FFF) begin
              r_nxt.ovf = 1'b1;
            end
            acc = t[15:0];
          end
          tz = (acc != 16'h0000);
          if (!r.ir[0]) begin
            skip = (r.ir[5] && !e0) || (r.ir[4] && !ts) || (r.ir[3] && !tl)
                   || (r.ir[1] && !tz);
          end else if (r.ir[5:1] == 5'h00 || r.ir[5:1] == 5'h02) begin
            skip = 1'b1;
          end else if (r.ir[4] && r.ir[3]) begin
            skip = (ts && tl) || (r.ir[5] && e0) || (r.ir[1] && tz);
          end else begin
            skip = (r.ir[5] && e0) || (r.ir[4] && ts) || (r.ir[3] && tl)
                   || (r.ir[1] && tz);
          end
        end else if (r.ir[15:12] == exec_pkg::GRP_IO && r.ir[10]) begin
          case (r.ir[8:6])
            exec_pkg::IO_STOP: r_nxt.halt = 1'b1;                    // RQ15
            exec_pkg::IO_FLAG: begin
              if (!r.ir[9] && sc == exec_pkg::SC_ALL) begin
                r_nxt.ien = 1'b1;
              end else if (!r.ir[9] && sc == exec_pkg::SC_OVF) begin
                r_nxt.ovf = 1'b1;
              end
            end
            exec_pkg::IO_LOAD: begin
              acc    = r.io_stable;                                  // RQ22
              wr_acc = 1'b1;
            end
            exec_pkg::IO_CTRL: begin
              if (r.ir[11] && sc == exec_pkg::SC_ALL) begin
                r_nxt.ctl_clr_all = 1'b1;                            // RQ8
              end else if (r.ir[11]) begin
                r_nxt.ctl_clr = 1'b1;                                // RQ8
              end
            end
            default: ;
          endcase
          if (r.ir[9]) begin                                         // RQ10
            if (sc == exec_pkg::SC_ALL) begin
              r_nxt.ien = 1'b0;                                      // RQ9
            end else if (sc == exec_pkg::SC_OVF) begin
              r_nxt.ovf = 1'b0;                                      // RQ11
            end else begin
              r_nxt.flag_clr = 1'b1;                                 // RQ9
            end
          end
        end else if (r.ir[14:12] != 3'h0) begin
          case (r.ir[14:11])
            exec_pkg::OP_OR_A: r_nxt.acc_a = r.acc_a | r.mem_opnd;  // RQ17
            exec_pkg::OP_CALL: begin
              r_nxt.mem_wdata = {1'b0, r.pc + 15'h0001};             // RQ20
              r_nxt.mem_waddr = ea;
              r_nxt.memwr     = 1'b1;
              tgt  = ea + 15'h0001;
              jump = 1'b1;
            end
            exec_pkg::OP_GOTO: begin
              tgt  = ea;                                             // RQ19
              jump = 1'b1;
            end
            exec_pkg::OP_BUMP: begin
              r_nxt.mem_wdata = r.mem_opnd + 16'h0001;               // RQ18
              r_nxt.mem_waddr = ea;
              r_nxt.memwr     = 1'b1;
              skip = (r.mem_opnd == 16'hFFFF);                       // RQ18
            end
            default: begin
              if (r.ir[14:12] == exec_pkg::OP_CPX) begin
                skip = (r.mem_opnd != acc);                          // RQ12
              end else if (r.ir[14:12] == exec_pkg::OP_LDX) begin
                acc    = r.mem_opnd;                                 // RQ21
                wr_acc = 1'b1;
              end
            end
          endcase
        end
        if (wr_acc && r.ir[11]) begin
          r_nxt.acc_b = acc;
        end else if (wr_acc) begin
          r_nxt.acc_a = acc;
        end
        if (r.ir[15:12] == exec_pkg::GRP_REG) begin
          r_nxt.ext = e;
        end
        if (jump) begin
          r_nxt.pc = tgt;
        end else begin
          r_nxt.pc = r.pc + (skip ? 15'h0002 : 15'h0001);            // RQ24
        end
      end
      default: r_nxt.st = exec_pkg::ST_IDLE;
    endcase
    r_nxt.ien_o = r_nxt.ien && !r_nxt.halt;                          // RQ15
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r        <= '0;
      r.st     <= exec_pkg::ST_IDLE;
      r.wait_r <= 1'b1;
      r.pc     <= exec_pkg::RST_PCOUNT;
      r.acc_a  <= exec_pkg::RST_ACC;
      r.acc_b  <= exec_pkg::RST_ACC;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_avs_readdata    = r.rdata;
  assign o_avs_waitrequest = r.wait_r;
  assign o_io_sel          = r.io_sel;
  assign o_ctl_clear       = r.ctl_clr;
  assign o_ctl_clear_all   = r.ctl_clr_all;
  assign o_flag_clear      = r.flag_clr;
  assign o_int_enable      = r.ien_o;
  assign o_halt            = r.halt;

  // ****************************************
  // Checks
  // ****************************************
  logic ex;
  logic ex_mref;
  assign ex      = (r.st == exec_pkg::ST_EXEC);
  assign ex_mref = ex && r.ir[15:12] != exec_pkg::GRP_IO && r.ir[14:12] != 3'h0;

  a_shift_left_sign: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ1
    ex && r.ir == 16'h0A00 |=> r.acc_b == {$past(r.acc_b[15]), $past(r.acc_b[13:0]), 1'b0})
    else $error("arithmetic left shift result wrong");
  a_shift_right_sign: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ3
    ex && r.ir == 16'h0A40 |=> r.acc_b[15:14] == {2{$past(r.acc_b[15])}})
    else $error("arithmetic right shift sign wrong");
  a_clear_acc_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ5
    ex && r.ir == 16'h0D00 |=> r.acc_b == 16'h0000)
    else $error("clear accumulator left bits set");
  a_compl_acc_inv: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ6
    ex && r.ir == 16'h0600 |=> r.acc_a == ~$past(r.acc_a))
    else $error("complement accumulator wrong");
  a_compare_skip_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ12
    ex_mref && r.ir[14:11] == 4'hA |=> r.pc == ($past(r.mem_opnd) != $past(r.acc_a) ?
      $past(r.pc) + 15'h0002 : $past(r.pc) + 15'h0001) && $stable(r.acc_a))
    else $error("compare skip advance wrong");
  a_or_into_acc: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ17
    ex_mref && r.ir[14:11] == exec_pkg::OP_OR_A
      |=> r.acc_a == ($past(r.acc_a) | $past(r.mem_opnd)))
    else $error("or into accumulator wrong");
  a_bump_keeps_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ18
    ex_mref && r.ir[14:11] == exec_pkg::OP_BUMP |=> $stable(r.ext) && $stable(r.ovf) && r.memwr)
    else $error("increment skip touched extend or overflow");
  a_jump_target: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ19
    ex_mref && r.ir[14:11] == exec_pkg::OP_GOTO && !r.ir[10]
      |=> r.pc == {5'h00, $past(r.ir[9:0])})
    else $error("jump target wrong");
  a_flag_zero_ien: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ9
    ex && r.ir[15:12] == exec_pkg::GRP_IO && r.ir[10] && r.ir[9] && r.ir[5:0] == 6'h00
      |=> !r.ien && !o_flag_clear ##1 !o_int_enable)
    else $error("clear flag code zero wrong");
  a_halt_blocks_int: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ15
    ex && r.ir[15:12] == exec_pkg::GRP_IO && r.ir[10] && r.ir[8:6] == exec_pkg::IO_STOP
      |=> o_halt && !o_int_enable && r.pc == $past(r.pc) + 15'h0001)
    else $error("halt effects wrong");

endmodule : minicomputer_instruction_execute

/* shared/exec_pkg.sv */
package exec_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 15;
  localparam int SC_W   = 6;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_INSTR     = 6'h00;
  localparam logic [5:0] OFS_ACC_A     = 6'h04;
  localparam logic [5:0] OFS_ACC_B     = 6'h08;
  localparam logic [5:0] OFS_PCOUNT    = 6'h0C;
  localparam logic [5:0] OFS_FLAGS     = 6'h10;
  localparam logic [5:0] OFS_MEM_OPND  = 6'h14;
  localparam logic [5:0] OFS_MEM_WDATA = 6'h18;
  localparam logic [5:0] OFS_MEM_WADDR = 6'h1C;

  // ****************************************
  // Flag register bit positions
  // ****************************************
  localparam int FLG_EXT   = 0;
  localparam int FLG_OVF   = 1;
  localparam int FLG_HALT  = 2;
  localparam int FLG_IEN   = 3;
  localparam int FLG_BUSY  = 4;
  localparam int FLG_MEMWR = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [14:0] RST_PCOUNT = 15'h0000;
  localparam logic [15:0] RST_ACC    = 16'h0000;

  // ****************************************
  // Instruction fields and codes
  // ****************************************
  localparam logic [3:0]  GRP_REG  = 4'h0;
  localparam logic [3:0]  GRP_IO   = 4'h8;
  localparam logic [3:0]  OP_OR_A  = 4'h6;
  localparam logic [3:0]  OP_CALL  = 4'h3;
  localparam logic [3:0]  OP_GOTO  = 4'h5;
  localparam logic [3:0]  OP_BUMP  = 4'h7;
  localparam logic [2:0]  OP_CPX   = 3'h5;
  localparam logic [2:0]  OP_LDX   = 3'h6;
  localparam logic [2:0]  IO_STOP  = 3'h0;
  localparam logic [2:0]  IO_FLAG  = 3'h1;
  localparam logic [2:0]  IO_LOAD  = 3'h5;
  localparam logic [2:0]  IO_CTRL  = 3'h7;
  localparam logic [5:0]  SC_ALL   = 6'h00;
  localparam logic [5:0]  SC_OVF   = 6'h01;
  localparam logic [2:0]  SH_ALS   = 3'h0;
  localparam logic [2:0]  SH_ARS   = 3'h1;
  localparam logic [2:0]  SH_RAL   = 3'h2;
  localparam logic [2:0]  SH_RAR   = 3'h3;
  localparam logic [2:0]  SH_ALR   = 3'h4;
  localparam logic [2:0]  SH_EXTR  = 3'h5;
  localparam logic [2:0]  SH_EXTL  = 3'h6;
  localparam logic [2:0]  SH_ALF   = 3'h7;
  localparam logic [1:0]  AC_CLR   = 2'h1;
  localparam logic [1:0]  AC_CMP   = 2'h2;
  localparam logic [1:0]  AC_SET   = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int IO_SETTLE_NS  = 100;
  localparam int IO_SETTLE_CYC = (IO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_IOWAIT = 2'h1,
    ST_EXEC   = 2'h3
  } exec_state_type;

endpackage : exec_pkg

/* bench/io_card_model.sv */
`timescale 1ns/100ps
// ****************************************
// Interface card buffers
// ****************************************
module io_card_model (
  // Select code from the processor
  input  wire logic [5:0]  i_sel,
  // Buffer word of the addressed card
  output logic      [15:0] o_data
);
  // Every card shows a word built from its own select code
  assign o_data = {4'hA, i_sel, ~i_sel};
endmodule : io_card_model

/* bench/minicomputer_instruction_execute_bench.sv */
`timescale 1ns/100ps
module minicomputer_instruction_execute_bench;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [5:0] RA = exec_pkg::OFS_ACC_A;
  localparam logic [5:0] RB = exec_pkg::OFS_ACC_B;
  localparam logic [5:0] RF = exec_pkg::OFS_FLAGS;
  localparam logic [5:0] RP = exec_pkg::OFS_PCOUNT;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [5:0]  address   = 6'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdata     = 32'h00000000;
  logic [31:0] rdata;
  logic        waitreq;
  logic [15:0] io_data;
  logic [5:0]  io_sel;
  logic        ctl, ctl_all, flg, ien, halt;
  logic [15:0] q;
  int          err_total   = 0;
  int          checks_done = 0;
  int          n_ctl = 0, n_all = 0, n_flg = 0;

  always #10 i_clk_sys = ~i_clk_sys;

  minicomputer_instruction_execute dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(address), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_io_data(io_data),
    .o_io_sel(io_sel), .o_ctl_clear(ctl), .o_ctl_clear_all(ctl_all), .o_flag_clear(flg),
    .o_int_enable(ien), .o_halt(halt));

  io_card_model card (.i_sel(io_sel), .o_data(io_data));

  // Pulse counters, so one-cycle strobes are never missed
  always @(posedge i_clk_sys) begin
    n_ctl <= n_ctl + int'(ctl);
    n_all <= n_all + int'(ctl_all);
    n_flg <= n_flg + int'(flg);
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    address <= a;
    wr      <= w;
    rd      <= ~w;
    wdata   <= {16'h0000, d};
    do begin
      @(posedge i_clk_sys);
    end while (waitreq !== 1'b0);
    q = rdata[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(nm, q, e);
  endtask : rdchk

  task automatic eo_chk(input logic [1:0] x);
    bus(1'b0, RF, 16'h0000);
    chk("ext_ovf", {14'h0, q[1:0]}, {14'h0, x});
  endtask : eo_chk

  // Issue a word and wait while the block reports busy
  task automatic exec(input logic [15:0] w);
    bus(1'b1, exec_pkg::OFS_INSTR, w);
    do bus(1'b0, RF, 16'h0000);
    while (q[exec_pkg::FLG_BUSY] !== 1'b0);
  endtask : exec

  task automatic op(input logic [15:0] w, input logic [5:0] r,
                    input logic [15:0] v, m, xv, input logic [1:0] f, xf);
    bus(1'b1, r, v);
    bus(1'b1, RF, {14'h0, f});
    bus(1'b1, exec_pkg::OFS_MEM_OPND, m);
    exec(w);
    rdchk("acc", r, xv);
    eo_chk(xf);
  endtask : op

  task automatic pc(input logic [15:0] w, a, m, xp);
    bus(1'b1, RP, 16'h0100);
    bus(1'b1, RA, a);
    bus(1'b1, RF, 16'h0003);
    bus(1'b1, exec_pkg::OFS_MEM_OPND, m);
    exec(w);
    rdchk("pcount", RP, xp);
    rdchk("acc_a", RA, a);
    eo_chk(2'b11);
  endtask : pc

  task automatic io(input logic [15:0] w, input int xc, xa, xf);
    int c0, a0, f0;
    c0 = n_ctl;
    a0 = n_all;
    f0 = n_flg;
    exec(w);
    chk("io_sel", {10'h0, io_sel}, {10'h0, w[5:0]});
    chk("ctl_clear", 16'(n_ctl - c0), 16'(xc));
    chk("ctl_clear_all", 16'(n_all - a0), 16'(xa));
    chk("flag_clear", 16'(n_flg - f0), 16'(xf));
  endtask : io

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_shift;
    op(16'h0A00, RB, 16'hC001, 16'h0000, 16'h8002, 2'b00, 2'b00);
    op(16'h0B00, RB, 16'hC001, 16'h0000, 16'h0002, 2'b00, 2'b00);
    op(16'h0A40, RB, 16'h8002, 16'h0000, 16'hC001, 2'b00, 2'b00);
    op(16'h0215, RA, 16'h4001, 16'h0000, 16'h8001, 2'b01, 2'b00);
    op(16'h0B80, RB, 16'h8001, 16'h0000, 16'h0002, 2'b00, 2'b01);
    op(16'h0B40, RB, 16'h0003, 16'h0000, 16'h8001, 2'b01, 2'b01);
  endtask : t_shift

  task automatic t_alter;
    op(16'h0700, RA, 16'h1234, 16'h0000, 16'hFFFF, 2'b00, 2'b00);
    op(16'h0D00, RB, 16'hFFFF, 16'h0000, 16'h0000, 2'b00, 2'b00);
    op(16'h0600, RA, 16'h5A0F, 16'h0000, 16'hA5F0, 2'b00, 2'b00);
    op(16'h0440, RA, 16'h0001, 16'h0000, 16'h0001, 2'b01, 2'b00);
    op(16'h0480, RA, 16'h0001, 16'h0000, 16'h0001, 2'b11, 2'b10);
    op(16'h04C0, RA, 16'h0001, 16'h0000, 16'h0001, 2'b00, 2'b01);
    op(16'h0404, RA, 16'h7FFF, 16'h0000, 16'h8000, 2'b00, 2'b10);
    op(16'h0C04, RB, 16'hFFFF, 16'h0000, 16'h0000, 2'b00, 2'b01);
    op(16'h8641, RA, 16'h0001, 16'h0000, 16'h0001, 2'b10, 2'b00);
  endtask : t_alter

  task automatic t_mem;
    op(16'h3010, RA, 16'h0F0F, 16'hF000, 16'hFF0F, 2'b00, 2'b00);
    op(16'h6810, RB, 16'h2222, 16'h1357, 16'h1357, 2'b00, 2'b00);
    op(16'h8D4B, RB, 16'h0000, 16'h0000, 16'hA2F4, 2'b00, 2'b00);
  endtask : t_mem

  task automatic t_flow;
    pc(16'h0000, 16'h0000, 16'h0000, 16'h0101);
    pc(16'h5010, 16'h0005, 16'h0005, 16'h0101);
    pc(16'h5010, 16'h0005, 16'h0006, 16'h0102);
    pc(16'h2955, 16'h0000, 16'h0000, 16'h0155);
    pc(16'h3820, 16'h0000, 16'hFFFF, 16'h0102);
    rdchk("mem_wdata", exec_pkg::OFS_MEM_WDATA, 16'h0000);
    pc(16'h3820, 16'h0000, 16'h0041, 16'h0101);
    pc(16'h1840, 16'h0000, 16'h0000, 16'h0041);
    rdchk("mem_wdata", exec_pkg::OFS_MEM_WDATA, 16'h0101);
    rdchk("mem_waddr", exec_pkg::OFS_MEM_WADDR, 16'h0040);
  endtask : t_flow

  task automatic t_io_halt;
    io(16'h8FC5, 1, 0, 1);
    io(16'h8DC0, 0, 1, 0);
    bus(1'b1, RF, 16'h0008);
    bus(1'b1, RP, 16'h0100);
    exec(16'h8405);
    chk("halt", {15'h0, halt}, 16'h0001);
    chk("int_enable", {15'h0, ien}, 16'h0000);
    rdchk("instr", exec_pkg::OFS_INSTR, 16'h8405);
    rdchk("pcount", RP, 16'h0101);
    bus(1'b1, RF, 16'h000C);
    @(posedge i_clk_sys);
    chk("int_enable", {15'h0, ien}, 16'h0001);
    io(16'h8640, 0, 0, 0);
    chk("int_enable", {15'h0, ien}, 16'h0000);
    io(16'h8647, 0, 0, 1);
  endtask : t_io_halt

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rdchk("pcount", RP, 16'h0000);
    rdchk("unmapped", 6'h24, 16'h0000);
    t_shift;
    t_alter;
    t_mem;
    t_flow;
    t_io_halt;
    test_done;
  end
endmodule : minicomputer_instruction_execute_bench
